// [verilog/wsd_top.sv]
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - word address held in 13-bit register; 12 bits used in 4K, 13 in 8K
// - address register has no async set or clear; changes only at clock edge
// - bits 13..2 come from inverted bus address lines into register inputs
// - bit 13 follows bus line 13 in 8K; captures zero in 4K
// - bit 1 loads from buffered low address bit from device selection
// - all register bits load together on rising edge of capture clock
// - bits 1,2,4,5,7,8,10,11 drive decoder select inputs directly
// - bits 6,12,13 decode to six active-low signals qualified by switch strobe
// - those six signals reach only the switch decoders
// - bits 3 and 9 ANDed with driver strobe, used only by driver decoders
// - switch strobe: read with read pulse, or write with write pulse
// - write is complement of read; read true while r/w state set
// - decoder: 4-bit select, weights 1,2,4,8; one of eight outputs low
// - weight-8 input high forces all eight outputs high
// - weight-4 input is active-low read: low picks 0-3, high picks 4-7
// - two lowest-weight inputs select one of four pairs
// - 8K uses ten decoders, six X four Y, 8192 unique selections
// - 4K uses eight decoders, four per axis, 4096 unique selections
// - driver decoder enables go low only while driver strobe is high
// - driver strobe: write pulse with read, or read pulse with write
// - low decoder output turns its switch or driver on
// - bus address lines are negative logic: low means one
module wsd_top
	import wsd_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [13:2] bus_addr_n,
	input wire logic buffered_low_address_bit,
	input wire logic capture_clk,
	input wire wsd_timing_t timing,
	output logic [WSD_NUM_DEC-1:0][WSD_DEC_OUTS-1:0] dec_out_n
);

	// ----------------------------------------------------------------
	// configuration and capture edge
	// ----------------------------------------------------------------
	logic size_8k_q;
	logic cap_q;
	logic cap_rise;
	logic [WSD_ADDR_MSB:WSD_ADDR_LSB] addr_d;
	logic [WSD_ADDR_MSB:WSD_ADDR_LSB] addr_q;
	logic [15:0] capcnt_q;

	// capture clock is sampled; its rising edge loads the word register
	// a capture clock held high across reset must not count as a new edge
	assign cap_rise = capture_clk & ~cap_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// reset as if already high: a real edge needs a low level first
			cap_q <= WSD_CAP_RST;
		end else begin
			cap_q <= capture_clk;
		end
	end

	// ----------------------------------------------------------------
	// word address register
	// ----------------------------------------------------------------
	// data inputs: receivers invert the negative-logic bus lines
	always_comb begin
		addr_d[12:2] = ~bus_addr_n[12:2];
		// 4K ties the bit-13 receiver input off, so it captures zero
		addr_d[13] = size_8k_q ? ~bus_addr_n[13] : 1'b0;
		addr_d[1] = buffered_low_address_bit;
	end

	// no reset on purpose: the register only ever follows its data inputs
	always_ff @(posedge pclk) begin
		if (cap_rise) begin
			addr_q <= addr_d;
		end
	end

	// capture counter, visible to software for bring-up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capcnt_q <= WSD_CAPCNT_RST;
		end else if (cap_rise) begin
			capcnt_q <= capcnt_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// read/write state and timing strobes
	// ----------------------------------------------------------------
	logic rd;
	logic wr;
	logic sw_strobe;
	logic drv_strobe;

	assign rd = timing.read_state;
	assign wr = ~rd;
	// switch strobe follows the operation's own phase pulse
	assign sw_strobe = (rd & timing.read_phase_pulse) | (wr & timing.write_phase_pulse);
	// driver strobe pairs the opposite pulse with the operation
	assign drv_strobe = (rd & timing.write_phase_pulse) | (wr & timing.read_phase_pulse);

	// ----------------------------------------------------------------
	// gating network
	// ----------------------------------------------------------------
	logic [5:0] sw_gate_n;
	logic [3:0] drv_gate_n;

	// six strobe-qualified block enables for the switch decoders only
	always_comb begin
		sw_gate_n[0] = ~(sw_strobe & addr_q[12] & addr_q[13]);
		sw_gate_n[1] = ~(sw_strobe & ~addr_q[12] & addr_q[13]);
		sw_gate_n[2] = ~(sw_strobe & addr_q[12] & ~addr_q[13]);
		sw_gate_n[3] = ~(sw_strobe & ~addr_q[12] & ~addr_q[13]);
		sw_gate_n[4] = ~(sw_strobe & addr_q[6]);
		sw_gate_n[5] = ~(sw_strobe & ~addr_q[6]);
	end

	// driver enables can only fall while the driver strobe is high
	always_comb begin
		drv_gate_n[0] = ~(drv_strobe & addr_q[3]);
		drv_gate_n[1] = ~(drv_strobe & ~addr_q[3]);
		drv_gate_n[2] = ~(drv_strobe & addr_q[9]);
		drv_gate_n[3] = ~(drv_strobe & ~addr_q[9]);
	end

	// ----------------------------------------------------------------
	// decoder inputs
	// ----------------------------------------------------------------
	wsd_dec_in_t dec_in [WSD_NUM_DEC];

	// switch decoders get gated enables, drivers get driver gates only
	always_comb begin
		dec_in[WSD_DEC_XSW_HH] = '{sw_gate_n[0], ~rd, addr_q[11:10]};
		dec_in[WSD_DEC_XSW_LH] = '{sw_gate_n[1], ~rd, addr_q[11:10]};
		dec_in[WSD_DEC_XSW_HL] = '{sw_gate_n[2], ~rd, addr_q[11:10]};
		dec_in[WSD_DEC_XSW_LL] = '{sw_gate_n[3], ~rd, addr_q[11:10]};
		dec_in[WSD_DEC_YSW_H] = '{sw_gate_n[4], ~rd, addr_q[8:7]};
		dec_in[WSD_DEC_YSW_L] = '{sw_gate_n[5], ~rd, addr_q[8:7]};
		dec_in[WSD_DEC_XDR_H] = '{drv_gate_n[0], ~rd, addr_q[2:1]};
		dec_in[WSD_DEC_XDR_L] = '{drv_gate_n[1], ~rd, addr_q[2:1]};
		dec_in[WSD_DEC_YDR_H] = '{drv_gate_n[2], ~rd, addr_q[5:4]};
		dec_in[WSD_DEC_YDR_L] = '{drv_gate_n[3], ~rd, addr_q[5:4]};
	end

	// ----------------------------------------------------------------
	// one-of-eight decoders
	// ----------------------------------------------------------------
	// kept combinational so a line drops the moment its strobe drops
	function automatic logic [7:0] wsd_decode(input wsd_dec_in_t din);
		logic [7:0] onehot;
		onehot = 8'h01 << {din.rw_n, din.sel};
		if (din.blk_en_n) begin
			wsd_decode = 8'hff;
		end else begin
			wsd_decode = ~onehot;
		end
	endfunction : wsd_decode

	// ten decoders; two X switch blocks never enable on an address captured in 4K
	for (genvar g = 0; g < WSD_NUM_DEC; g++) begin : g_dec
		assign dec_out_n[g] = wsd_decode(dec_in[g]);
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic setup_ph;
	logic [7:0] reg_ofs;
	logic ofs_hit;
	logic [31:0] rdata_d;

	assign setup_ph = psel & ~penable;
	assign reg_ofs = paddr[7:0];
	assign ofs_hit = (reg_ofs == WSD_OFS_CFG) | (reg_ofs == WSD_OFS_WADDR) |
		(reg_ofs == WSD_OFS_STATUS) | (reg_ofs == WSD_OFS_CAPCNT);

	// read mux; unused bits read zero
	always_comb begin
		rdata_d = WSD_RDATA_RST;
		case (reg_ofs)
			WSD_OFS_CFG: begin
				rdata_d[WSD_CFG_SIZE8K_BIT] = size_8k_q;
			end
			WSD_OFS_WADDR: begin
				rdata_d[WSD_ADDR_MSB:WSD_ADDR_LSB] = addr_q;
			end
			WSD_OFS_STATUS: begin
				rdata_d[WSD_ST_READ_BIT] = rd;
				rdata_d[WSD_ST_SWSTB_BIT] = sw_strobe;
				rdata_d[WSD_ST_DRVSTB_BIT] = drv_strobe;
				rdata_d[WSD_ST_CAPLVL_BIT] = cap_q;
			end
			WSD_OFS_CAPCNT: begin
				rdata_d[15:0] = capcnt_q;
			end
			default: begin
				rdata_d = WSD_RDATA_RST;
			end
		endcase
	end

	// answer prepared in setup so the access phase completes at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= WSD_RDATA_RST;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~ofs_hit;
			prdata <= (setup_ph & ~pwrite) ? rdata_d : WSD_RDATA_RST;
		end
	end

	// configuration write, taken at the completing edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			size_8k_q <= WSD_CFG_SIZE8K_RST;
		end else if (psel && penable && pready && pwrite && reg_ofs == WSD_OFS_CFG) begin
			size_8k_q <= pwdata[WSD_CFG_SIZE8K_BIT];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// the word register has no reset, so hold checks wait for its first load
	logic addr_seen_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_seen_q <= 1'b0;
		end else if (cap_rise) begin
			addr_seen_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// word address register checks
	// ----------------------------------------------------------------
	a_capture_load: assert property (cap_rise |=> addr_q == $past(addr_d))
		else $error("word register did not load on capture edge");
	a_hold_between: assert property (addr_seen_q && !cap_rise |=> $stable(addr_q))
		else $error("word register changed without capture edge");
	// bit 13 depends on the size bit standing at the capture edge
	a_bit13_small: assert property (cap_rise && !size_8k_q |=> !addr_q[13])
		else $error("bit 13 set in 4K configuration");
	a_bit13_big: assert property (cap_rise && size_8k_q |=> addr_q[13] == !$past(bus_addr_n[13]))
		else $error("bit 13 did not follow the bus in 8K configuration");
	a_bus_invert: assert property (cap_rise |=> addr_q[12:2] == ~$past(bus_addr_n[12:2]))
		else $error("bus address not inverted into register");
	a_low_bit: assert property (cap_rise |=> addr_q[1] == $past(buffered_low_address_bit))
		else $error("bit 1 not taken from the buffered low address bit");

	// ----------------------------------------------------------------
	// strobe and gating checks
	// ----------------------------------------------------------------
	// judged from the control pins, so a wrong strobe equation shows here too
	a_sw_pulse: assert property ((timing.read_state ? !timing.read_phase_pulse : !timing.write_phase_pulse)
		|-> &dec_out_n[WSD_DEC_YSW_L:WSD_DEC_XSW_HH])
		else $error("switch decoder active outside its phase pulse");
	a_drv_pulse: assert property ((timing.read_state ? !timing.write_phase_pulse : !timing.read_phase_pulse)
		|-> &dec_out_n[WSD_DEC_YDR_L:WSD_DEC_XDR_H])
		else $error("driver decoder active outside its phase pulse");
	a_idle_none: assert property (!sw_strobe && !drv_strobe |-> &dec_out_n)
		else $error("line selected with both strobes idle");
	a_drv_gated: assert property (!drv_strobe |-> &{dec_out_n[9], dec_out_n[8], dec_out_n[7], dec_out_n[6]})
		else $error("driver decoder active without driver strobe");
	// the six switch enables: one x block and one y block at most
	a_one_block: assert property ($onehot0({~&dec_out_n[WSD_DEC_XSW_LL], ~&dec_out_n[WSD_DEC_XSW_HL],
		~&dec_out_n[WSD_DEC_XSW_LH], ~&dec_out_n[WSD_DEC_XSW_HH]}))
		else $error("two x switch blocks enabled at once");
	a_y_one: assert property (sw_strobe |-> ((&dec_out_n[WSD_DEC_YSW_H]) != (&dec_out_n[WSD_DEC_YSW_L])))
		else $error("y switch blocks not exactly one enabled");

	// ----------------------------------------------------------------
	// line decoder checks
	// ----------------------------------------------------------------
	// one line of one block, picked by the select bits and the direction
	a_sw_pick: assert property (sw_strobe && addr_q[6] |->
		!dec_out_n[WSD_DEC_YSW_H][{~rd, addr_q[8], addr_q[7]}] && &dec_out_n[WSD_DEC_YSW_L])
		else $error("wrong y switch line selected");
	a_x_direct: assert property (sw_strobe && !addr_q[12] && !addr_q[13] |->
		!dec_out_n[WSD_DEC_XSW_LL][{~rd, addr_q[11], addr_q[10]}])
		else $error("x switch line does not follow bits 11 and 10");
	a_drv_pick: assert property (drv_strobe && addr_q[9] |->
		!dec_out_n[WSD_DEC_YDR_H][{~rd, addr_q[5], addr_q[4]}] && &dec_out_n[WSD_DEC_YDR_L])
		else $error("wrong y driver line selected");
	a_x_drv_pick: assert property (drv_strobe && !addr_q[3] |->
		!dec_out_n[WSD_DEC_XDR_L][{~rd, addr_q[2], addr_q[1]}] && &dec_out_n[WSD_DEC_XDR_H])
		else $error("wrong x driver line selected");
	a_read_half: assert property (rd && sw_strobe |-> &dec_out_n[WSD_DEC_XSW_LL][7:4])
		else $error("write half selected during read");
	a_write_half: assert property (wr && drv_strobe |->
		&dec_out_n[WSD_DEC_XDR_H][3:0] && &dec_out_n[WSD_DEC_XDR_L][3:0])
		else $error("read half selected during write");
	a_one_low: assert property ($onehot0(~dec_out_n[WSD_DEC_XDR_H]) && $onehot0(~dec_out_n[WSD_DEC_XSW_HH]))
		else $error("more than one decoder output low");

	// ----------------------------------------------------------------
	// register bus checks
	// ----------------------------------------------------------------
	// the answer always comes one cycle after setup, never later
	a_apb_answer: assert property (setup_ph |=> pready && (pslverr == !$past(ofs_hit)))
		else $error("apb access not answered in one cycle");
	// pready is a pulse: setup and access never overlap
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready high for two cycles");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// read data stays zero outside an access
	a_rdata_quiet: assert property (!pready |-> prdata == WSD_RDATA_RST)
		else $error("read data not zero outside an access");
	// the completing edge of a cfg write loads the size bit from pwdata
	a_cfg_write: assert property (psel && penable && pready && pwrite && reg_ofs == WSD_OFS_CFG |=>
		size_8k_q == $past(pwdata[WSD_CFG_SIZE8K_BIT]))
		else $error("size bit not taken from a completed write");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	// the main scenarios: read and write, 4K and 8K, held capture clock
	c_read_switch: cover property (rd && sw_strobe && !size_8k_q);
	c_write_driver: cover property (wr && drv_strobe && size_8k_q);
	c_capture_8k: cover property (cap_rise && size_8k_q && !bus_addr_n[13]);
	c_bad_addr: cover property (pslverr && pready);
	c_held_clock: cover property (capture_clk && cap_q && addr_seen_q);

endmodule : wsd_top

// [common/wsd_pkg.sv]
package wsd_pkg;

	// ----------------------------------------------------------------
	// register map (apb, byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] WSD_OFS_CFG = 8'h00;
	localparam logic [7:0] WSD_OFS_WADDR = 8'h04;
	localparam logic [7:0] WSD_OFS_STATUS = 8'h08;
	localparam logic [7:0] WSD_OFS_CAPCNT = 8'h0c;

	// field positions
	localparam int WSD_CFG_SIZE8K_BIT = 0;
	localparam int WSD_ST_READ_BIT = 0;
	localparam int WSD_ST_SWSTB_BIT = 1;
	localparam int WSD_ST_DRVSTB_BIT = 2;
	localparam int WSD_ST_CAPLVL_BIT = 3;

	// reset values
	localparam logic WSD_CFG_SIZE8K_RST = 1'b0;
	localparam logic [15:0] WSD_CAPCNT_RST = 16'h0000;
	localparam logic [31:0] WSD_RDATA_RST = 32'h0000_0000;
	localparam logic WSD_CAP_RST = 1'b1; // capture level assumed during reset

	// ----------------------------------------------------------------
	// word address and decoder layout
	// ----------------------------------------------------------------
	localparam int WSD_ADDR_MSB = 13;
	localparam int WSD_ADDR_LSB = 1;
	localparam int WSD_NUM_DEC = 10;
	localparam int WSD_DEC_OUTS = 8;

	// decoder indices on the selection port
	localparam int WSD_DEC_XSW_HH = 0; // x switches, bit12=1 bit13=1
	localparam int WSD_DEC_XSW_LH = 1; // bit12=0 bit13=1
	localparam int WSD_DEC_XSW_HL = 2; // bit12=1 bit13=0
	localparam int WSD_DEC_XSW_LL = 3; // bit12=0 bit13=0
	localparam int WSD_DEC_YSW_H = 4; // y switches, bit6=1
	localparam int WSD_DEC_YSW_L = 5; // bit6=0
	localparam int WSD_DEC_XDR_H = 6; // x drivers, bit3=1
	localparam int WSD_DEC_XDR_L = 7; // bit3=0
	localparam int WSD_DEC_YDR_H = 8; // y drivers, bit9=1
	localparam int WSD_DEC_YDR_L = 9; // bit9=0

	// one decoder's four select inputs, weights 8/4/2/1
	typedef struct packed {
		logic blk_en_n; // weight 8, active-low block enable
		logic rw_n; // weight 4, active-low read
		logic [1:0] sel; // weights 2 and 1
	} wsd_dec_in_t;

	// timing pulses and read/write state from the bank control logic
	typedef struct packed {
		logic read_state;
		logic read_phase_pulse;
		logic write_phase_pulse;
	} wsd_timing_t;

endpackage : wsd_pkg

// [tb/wsd_ctl_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bank control logic and bus stand-in
// ----------------------------------------------------------------
module wsd_ctl_model
	import wsd_pkg::*;
(
	input wire logic pclk,
	output logic [13:2] bus_addr_n,
	output logic buffered_low_address_bit,
	output logic capture_clk,
	output wsd_timing_t timing
);
	// idle bus rests high through its terminators, i.e. logical zero
	initial begin
		bus_addr_n = '1;
		buffered_low_address_bit = 1'b0;
		capture_clk = 1'b0;
		timing = '0;
	end
	// present an address, give one rising capture edge, then let the bus go
	task automatic load(input logic [13:1] a, input logic rd, input logic hold);
		@(posedge pclk);
		capture_clk <= 1'b0;
		bus_addr_n <= ~a[13:2];
		buffered_low_address_bit <= a[1];
		timing <= '{read_state: rd, default: 1'b0};
		@(posedge pclk);
		capture_clk <= 1'b1;
		@(posedge pclk);
		capture_clk <= hold; // held high must not reload
		bus_addr_n <= '1;
		buffered_low_address_bit <= ~a[1]; // stale bit flipped so a late load shows
	endtask
	// one timing phase, levels held until the next call
	task automatic phase(input logic rp, input logic wp);
		@(posedge pclk);
		timing.read_phase_pulse <= rp;
		timing.write_phase_pulse <= wp;
	endtask
endmodule : wsd_ctl_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import wsd_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, buffered_low_address_bit, capture_clk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [13:2] bus_addr_n;
	wsd_timing_t timing;
	logic [WSD_NUM_DEC-1:0][WSD_DEC_OUTS-1:0] dec_out_n;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	// ----------------------------------------------------------------
	// clock, reset, instances
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	wsd_top #(.ADDR_W(8)) i_wsd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_addr_n(bus_addr_n), .buffered_low_address_bit(buffered_low_address_bit),
		.capture_clk(capture_clk), .timing(timing), .dec_out_n(dec_out_n));
	wsd_ctl_model i_wsd_ctl_model (.pclk(pclk), .bus_addr_n(bus_addr_n),
		.buffered_low_address_bit(buffered_low_address_bit), .capture_clk(capture_clk), .timing(timing));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// one apb transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [32:0] e);
		logic [32:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		chk(nm, {47'b0, e}, {47'b0, r});
	endtask
	// reference decoder outputs, worked out from address, direction and pulses
	function automatic logic [9:0][7:0] exp_dec(input logic [13:1] a, input logic rd, input logic rp, input logic wp);
		logic sw, dr;
		logic [9:0] en;
		logic [9:0][1:0] s;
		logic [9:0][7:0] r;
		sw = (rd & rp) | (!rd & wp);
		dr = (rd & wp) | (!rd & rp);
		en = {dr & !a[9], dr & a[9], dr & !a[3], dr & a[3], sw & !a[6], sw & a[6],
			sw & !a[12] & !a[13], sw & a[12] & !a[13], sw & !a[12] & a[13], sw & a[12] & a[13]};
		s = {{2{a[5:4]}}, {2{a[2:1]}}, {2{a[8:7]}}, {4{a[11:10]}}};
		r = '1;
		for (int i = 0; i < 10; i++)
			if (en[i]) r[i][{!rd, s[i]}] = 1'b0;
		return r;
	endfunction
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		rd_chk("cfg", WSD_OFS_CFG, {32'b0, WSD_CFG_SIZE8K_RST});
		rd_chk("capcnt", WSD_OFS_CAPCNT, {17'b0, WSD_CAPCNT_RST});
		rd_chk("unmapped", 8'h10, {1'b1, 32'h0000_0000});
	endtask
	// four address patterns, both directions, all four pulse combinations
	task automatic t_sel(input logic big);
		logic [13:1] tbl [4] = '{13'h1FFD, 13'h0000, 13'h1555, 13'h0AAA};
		logic [13:1] am;
		logic [32:0] r;
		apb(1'b1, WSD_OFS_CFG, {31'b0, big}, r);
		for (int k = 0; k < 8; k++) begin
			am = tbl[k / 2];
			am[13] = am[13] & big;
			i_wsd_ctl_model.load(tbl[k / 2], k[0], 1'b0);
			rd_chk("waddr", WSD_OFS_WADDR, {19'b0, am, 1'b0});
			for (int ph = 0; ph < 4; ph++) begin
				i_wsd_ctl_model.phase(ph[0], ph[1]);
				#1;
				chk("dec", exp_dec(am, k[0], ph[0], ph[1]), dec_out_n);
			end
		end
	endtask
	// capture held high must not reload; reset must not clear the address
	task automatic t_keep;
		i_wsd_ctl_model.load(13'h1555, 1'b1, 1'b1);
		repeat (3) @(posedge pclk);
		rd_chk("held", WSD_OFS_WADDR, {19'b0, 13'h1555, 1'b0});
		rd_chk("status", WSD_OFS_STATUS, {29'b0, 4'h9});
		rd_chk("captures", WSD_OFS_CAPCNT, {17'b0, 16'h0011});
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("after reset", WSD_OFS_WADDR, {19'b0, 13'h1555, 1'b0});
		rd_chk("cfg after reset", WSD_OFS_CFG, {32'b0, WSD_CFG_SIZE8K_RST});
		rd_chk("no capture at reset", WSD_OFS_CAPCNT, {17'b0, WSD_CAPCNT_RST});
	endtask
	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	initial begin
		forever begin
			@(posedge pclk);
			cycles++;
			if (cycles >= 5000) begin
				fail_count++;
				end_of_test;
			end
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_sel(1'b0);
		t_sel(1'b1);
		t_keep;
		end_of_test;
	end
endmodule : tb
